// File: hdl/amp_output_fault_diagnostics.sv
// Output-fault diagnostics sequencer for a four-channel bridge amplifier
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - On host request, run turn-on pulse diagnostic at standby exit for all faults.
// - Turn-on result is held until a new pulse is requested after a read.
// - Standby exit with diag enable together: pulse first, stage standby, outputs hi-Z.
// - Once biased, permanent diagnostic runs; turn-on result kept until a short appears.
// - Output status captured at end of pulse top, about 100 ms acquisition.
// - Ground and supply short thresholds are the same at either gain.
// - Line-driver load thresholds only with 16 dB gain and line-driver select set.
// - Permanent diagnostic finds ground, supply and across shorts, plus output offset.
// - Restart mode shuts only the faulted channel, checks every 1 ms, restarts.
// - In diagnostic mode, recheck 1 ms after protection trips; clear means resume.
// - Overload still present at recheck starts a diagnostic cycle of about 100 ms.
// - After the cycle, channel goes to restart mode and fault data are stored.
// - Per-channel offset flagged when magnitude exceeds 2 V either polarity.
// - Offset interval starts at last read or offset enable, ends at next read; current-detect enable restarts it too.
// - Offset reported only if present for the whole interval.
// - Protection tripping during the test suppresses offset and current detection.
// - Peak current above 500 mA is normal load, below 250 mA open tweeter.
// - Open tweeter reported unless at least three pulses above 500 mA counted.
// - With several faults only the highest-priority result is reported; later reads repeat it.
// - Double-fault priority: source ground plus supply both, else source ground wins.
// - Test current source is positive on left-front/right-rear, negative otherwise.
// - Permanent diagnostic never reports open load; only turn-on finds it.
// - Every status read re-arms all cycles; returned data come from the previous cycle.
// - Diag enable bit enables diagnostics; clearing it leaves channels in restart mode.
module amp_output_fault_diagnostics #(
    parameter int RECHECK_CYCLES = diag_pkg::RECHECK_CYC,
    parameter int DIAG_CYCLES = diag_pkg::DIAG_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Per-channel analog comparator levels, asynchronous
    input wire diag_pkg::flt_in_s [3:0] flt_in,
    // Power stage control
    output logic stage_standby,
    output logic outputs_hiz,
    output logic test_pulse,
    output logic [3:0] chan_en,
    output logic [3:0] line_thr_sel
);

    // Timers are TMR_W wide and compare against count minus one
    if (RECHECK_CYCLES < 2 || DIAG_CYCLES < 2 || DIAG_CYCLES >= (1 << diag_pkg::TMR_W) ||
        RECHECK_CYCLES >= (1 << diag_pkg::TMR_W)) begin : g_bad_timing
        $error("Timer parameters out of range");
    end

    localparam logic [diag_pkg::TMR_W-1:0] RECHK_LAST = diag_pkg::TMR_W'(RECHECK_CYCLES - 1);
    localparam logic [diag_pkg::TMR_W-1:0] DIAG_LAST = diag_pkg::TMR_W'(DIAG_CYCLES - 1);

    // Reset release and input synchronisers
    logic [1:0] rst_sync_r;
    logic rst_n;
    diag_pkg::flt_in_s [3:0] flt_meta_r, flt_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flt_meta_r <= '0;
            flt_r <= '0;
        end else begin
            flt_meta_r <= flt_in;
            flt_r <= flt_meta_r;
        end
    end

    // Bus slave, one wait cycle per access
    diag_pkg::ctrl_s ctrl_r, ctrl_nxt;
    logic wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic rd_evt, offset_rise, cd_rise;
    diag_pkg::result_s [3:0] report_r, report_nxt;
    diag_pkg::result_s [3:0] live_r;
    diag_pkg::ton_state_e ton_r, ton_nxt;
    diag_pkg::chan_state_e [3:0] cst_r;
    logic [3:0] chan_en_r;

    always_comb begin
        ctrl_nxt = ctrl_r;
        wait_nxt = 1'b1;
        rdata_nxt = rdata_r;
        rd_evt = 1'b0;
        if ((read || write) && wait_r) begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h0;
            if (write && address == diag_pkg::CTRL_ADDR) begin
                ctrl_nxt = diag_pkg::ctrl_s'(writedata[6:0]);
            end
            if (read) begin
                case (address)
                    diag_pkg::CTRL_ADDR: rdata_nxt = {25'h0, ctrl_r};
                    diag_pkg::STATUS_ADDR: begin
                        rdata_nxt = report_r;
                        rd_evt = 1'b1;
                    end
                    diag_pkg::STATE_ADDR: rdata_nxt = {1'h0, ton_r, cst_r, 8'h0, chan_en_r};
                    default: rdata_nxt = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= diag_pkg::CTRL_RST;
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            wait_r <= wait_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    assign offset_rise = ctrl_nxt.offset_en && !ctrl_r.offset_en;
    assign cd_rise = ctrl_nxt.cur_det_en && !ctrl_r.cur_det_en;

    // Double-fault priority with source/sink side resolution
    function automatic diag_pkg::result_s classify(input diag_pkg::flt_in_s f, input logic src_pos,
                                                   input logic allow_open);
        logic so;
        logic sk;
        diag_pkg::result_s r;
        so = src_pos ? f.gnd_pos : f.gnd_neg;
        sk = src_pos ? f.gnd_neg : f.gnd_pos;
        r = '0;
        r.done = 1'b1;
        if (so && f.vs_short) begin
            r.gnd = 1'b1;
            r.vs_short = 1'b1;
        end else if (so) begin
            r.gnd = 1'b1;
        end else if (f.vs_short) begin
            r.vs_short = 1'b1;
        end else if (sk && f.open_ld && allow_open) begin
            r.open_ld = 1'b1;
        end else if (sk) begin
            r.gnd = 1'b1;
        end else if (f.across) begin
            r.across = 1'b1;
        end else if (f.open_ld && allow_open) begin
            r.open_ld = 1'b1;
        end
        return r;
    endfunction

    // Turn-on diagnostic sequencer
    logic ton_armed_r, ton_armed_nxt;
    logic [diag_pkg::TMR_W-1:0] ton_tmr_r, ton_tmr_nxt;
    logic ton_end;

    always_comb begin
        ton_nxt = ton_r;
        ton_tmr_nxt = '0;
        ton_armed_nxt = ton_armed_r || rd_evt;
        ton_end = 1'b0;
        case (ton_r)
            diag_pkg::TS_STBY: begin
                if (ctrl_r.standby_off) begin
                    if (ctrl_r.diag_en && ton_armed_r) begin
                        ton_nxt = diag_pkg::TS_PULSE;
                        // A read in this very cycle still asks for the next pulse
                        ton_armed_nxt = rd_evt;
                    end else begin
                        ton_nxt = diag_pkg::TS_BIAS;
                    end
                end
            end
            diag_pkg::TS_PULSE: begin
                ton_tmr_nxt = ton_tmr_r + 1'b1;
                if (ton_tmr_r == DIAG_LAST) begin
                    ton_end = 1'b1;
                    ton_tmr_nxt = '0;
                    ton_nxt = ctrl_r.standby_off ? diag_pkg::TS_BIAS : diag_pkg::TS_STBY;
                end
            end
            diag_pkg::TS_BIAS: begin
                if (!ctrl_r.standby_off) begin
                    ton_nxt = diag_pkg::TS_STBY;
                end
            end
            default: ton_nxt = diag_pkg::TS_STBY;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ton_r <= diag_pkg::TS_STBY;
            ton_tmr_r <= '0;
            ton_armed_r <= 1'b1;
            stage_standby <= 1'b1;
            outputs_hiz <= 1'b1;
            test_pulse <= 1'b0;
        end else begin
            ton_r <= ton_nxt;
            ton_tmr_r <= ton_tmr_nxt;
            ton_armed_r <= ton_armed_nxt;
            stage_standby <= ton_nxt != diag_pkg::TS_BIAS;
            outputs_hiz <= ton_nxt != diag_pkg::TS_BIAS;
            test_pulse <= ton_nxt == diag_pkg::TS_PULSE;
        end
    end

    // Per-channel permanent diagnostic, offset and current detection
    for (genvar c = 0; c < diag_pkg::NUM_CH; c++) begin : g_ch
        diag_pkg::chan_state_e st_nxt;
        logic [diag_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
        logic armed_r, armed_nxt, en_nxt;
        diag_pkg::result_s live_nxt, cls;
        logic off_ok_r, off_ok_nxt, scp_seen_r, scp_seen_nxt;
        logic cur_prev_r;
        logic [1:0] pulses_r, pulses_nxt;
        logic gain16;

        assign gain16 = diag_pkg::CH_IS_FRONT[c] ? ctrl_r.gain_front16 : ctrl_r.gain_rear16;

        always_comb begin
            st_nxt = cst_r[c];
            tmr_nxt = tmr_r + 1'b1;
            armed_nxt = armed_r || rd_evt;
            live_nxt = live_r[c];
            cls = '0;
            if (rd_evt) begin
                live_nxt.done = 1'b0;
            end
            if (ton_end) begin
                live_nxt = classify(flt_r[c], diag_pkg::SRC_IS_POS[c], 1'b1);
            end
            case (cst_r[c])
                diag_pkg::CS_ACTIVE: begin
                    tmr_nxt = '0;
                    if (flt_r[c].scp && ton_r == diag_pkg::TS_BIAS) begin
                        st_nxt = (ctrl_r.diag_en && armed_r) ? diag_pkg::CS_RECHECK
                                                            : diag_pkg::CS_RESTART;
                    end
                end
                diag_pkg::CS_RECHECK: begin
                    if (tmr_r == RECHK_LAST) begin
                        tmr_nxt = '0;
                        st_nxt = flt_r[c].scp ? diag_pkg::CS_DIAG : diag_pkg::CS_ACTIVE;
                    end
                end
                diag_pkg::CS_DIAG: begin
                    if (tmr_r == DIAG_LAST) begin
                        tmr_nxt = '0;
                        st_nxt = diag_pkg::CS_RESTART;
                        armed_nxt = rd_evt;
                        cls = classify(flt_r[c], diag_pkg::SRC_IS_POS[c], 1'b0);
                        if (cls.gnd || cls.vs_short || cls.across) begin
                            live_nxt = cls;
                            live_nxt.perm = 1'b1;
                        end else begin
                            live_nxt.done = 1'b1;
                        end
                    end
                end
                diag_pkg::CS_RESTART: begin
                    if (tmr_r == RECHK_LAST) begin
                        tmr_nxt = '0;
                        if (!flt_r[c].scp) begin
                            st_nxt = diag_pkg::CS_ACTIVE;
                        end
                    end
                end
                default: st_nxt = diag_pkg::CS_ACTIVE;
            endcase
            if (ton_r != diag_pkg::TS_BIAS) begin
                st_nxt = diag_pkg::CS_ACTIVE;
                tmr_nxt = '0;
            end
            en_nxt = ton_nxt == diag_pkg::TS_BIAS && st_nxt == diag_pkg::CS_ACTIVE;

            // Offset must hold over the whole interval; a protection trip voids both tests
            off_ok_nxt = off_ok_r && flt_r[c].offset_hi;
            scp_seen_nxt = scp_seen_r;
            pulses_nxt = pulses_r;
            if (rd_evt || offset_rise || cd_rise) begin
                off_ok_nxt = 1'b1;
                scp_seen_nxt = 1'b0;
                pulses_nxt = 2'h0;
            end
            if (flt_r[c].scp) begin
                scp_seen_nxt = 1'b1;
            end
            // Counts on top of a restart, so a pulse at the read opens the new interval
            if (flt_r[c].cur_hi && !cur_prev_r && pulses_nxt != 2'(diag_pkg::PULSE_MIN)) begin
                pulses_nxt = pulses_nxt + 1'b1;
            end

            report_nxt[c] = report_r[c];
            if (rd_evt) begin
                report_nxt[c] = live_r[c];
                report_nxt[c].offset = ctrl_r.offset_en && off_ok_r && !scp_seen_r;
                report_nxt[c].open_tw = ctrl_r.cur_det_en && !scp_seen_r &&
                                        pulses_r != 2'(diag_pkg::PULSE_MIN);
            end
        end

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cst_r[c] <= diag_pkg::CS_ACTIVE;
                tmr_r <= '0;
                armed_r <= 1'b1;
                live_r[c] <= '0;
                report_r[c] <= '0;
                off_ok_r <= 1'b0;
                scp_seen_r <= 1'b0;
                cur_prev_r <= 1'b0;
                pulses_r <= 2'h0;
                chan_en_r[c] <= 1'b0;
                line_thr_sel[c] <= 1'b0;
            end else begin
                cst_r[c] <= st_nxt;
                tmr_r <= tmr_nxt;
                armed_r <= armed_nxt;
                live_r[c] <= live_nxt;
                report_r[c] <= report_nxt[c];
                off_ok_r <= off_ok_nxt;
                scp_seen_r <= scp_seen_nxt;
                cur_prev_r <= flt_r[c].cur_hi;
                pulses_r <= pulses_nxt;
                chan_en_r[c] <= en_nxt;
                line_thr_sel[c] <= gain16 && ctrl_r.line_drv_diag;
            end
        end
    end

    assign readdata = rdata_r;
    assign waitrequest = wait_r;
    assign chan_en = chan_en_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_PULSE_FIRST: assert property ($rose(test_pulse) |-> stage_standby && outputs_hiz)
        else $error("Pulse ran with stage out of standby");
    AST_PULSE_LEN: assert property ($rose(test_pulse) |-> test_pulse [*8])
        else $error("Pulse shorter than expected");
    AST_PULSE_REQ: assert property ($rose(test_pulse) |-> $past(ctrl_r.diag_en) && $past(ctrl_r.standby_off))
        else $error("Pulse without request");
    AST_LINE_THR: assert property (line_thr_sel[0] |-> $past(ctrl_r.gain_front16 && ctrl_r.line_drv_diag))
        else $error("Line thresholds without 16 dB and select");
    AST_RESTART_OFF: assert property (cst_r[1] == diag_pkg::CS_RESTART |-> !chan_en[1])
        else $error("Faulted channel left enabled");
    AST_NO_DIAG_DEFEAT: assert property (cst_r[0] == diag_pkg::CS_ACTIVE && flt_r[0].scp && !ctrl_r.diag_en &&
        ton_r == diag_pkg::TS_BIAS |=> cst_r[0] == diag_pkg::CS_RESTART)
        else $error("Defeated diagnostic did not enter restart");
    AST_RECHECK_TO_DIAG: assert property (cst_r[1] == diag_pkg::CS_RECHECK && g_ch[1].tmr_r == RECHK_LAST &&
        flt_r[1].scp && ton_r == diag_pkg::TS_BIAS |=> cst_r[1] == diag_pkg::CS_DIAG)
        else $error("Recheck did not start a diagnostic cycle");
    AST_PERM_NO_OPEN: assert property ($rose(live_r[1].perm) |-> !live_r[1].open_ld)
        else $error("Permanent result shows open load");
    AST_READ_SHIFT: assert property (rd_evt |=> report_r[0][4:0] == $past(live_r[0][4:0]))
        else $error("Read did not shift previous cycle into report");
    AST_SCP_VOIDS: assert property (rd_evt && g_ch[0].scp_seen_r |=> !report_r[0].offset && !report_r[0].open_tw)
        else $error("Offset or current result survived a protection trip");
    AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("Bus answer not one cycle");

    COV_PULSE: cover property ($fell(test_pulse));
    COV_PERM: cover property (cst_r[0] == diag_pkg::CS_DIAG ##1 cst_r[0] == diag_pkg::CS_RESTART);
    COV_RESUME: cover property (cst_r[0] == diag_pkg::CS_RECHECK ##1 cst_r[0] == diag_pkg::CS_ACTIVE);
    COV_OFFSET: cover property (rd_evt ##1 report_r[0].offset);

endmodule

`default_nettype wire

// File: hdl/diag_pkg.sv
// Shared constants, types and register map of the output-fault diagnostics block
package diag_pkg;

    // Channel order: 0 left_front_channel, 1 left_rear_channel, 2 right_front_channel, 3 right_rear_channel
    localparam int NUM_CH = 4;
    localparam logic [3:0] SRC_IS_POS = 4'h9;
    localparam logic [3:0] CH_IS_FRONT = 4'h5;

    // Timing, clock 250 MHz
    localparam int CLK_KHZ = 250000;
    localparam int RECHECK_MS = 1;
    localparam int DIAG_MS = 100;
    localparam int RECHECK_CYC = RECHECK_MS * CLK_KHZ;
    localparam int DIAG_CYC = DIAG_MS * CLK_KHZ;
    localparam int TMR_W = 25;
    localparam int PULSE_MIN = 3;

    // Register byte addresses (word aligned)
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] STATE_ADDR = 4'h8;
    localparam logic [6:0] CTRL_RST = 7'h00;

    typedef struct packed {
        logic standby_off;
        logic line_drv_diag;
        logic cur_det_en;
        logic gain_rear16;
        logic gain_front16;
        logic offset_en;
        logic diag_en;
    } ctrl_s;

    typedef struct packed {
        logic gnd_pos;
        logic gnd_neg;
        logic vs_short;
        logic across;
        logic open_ld;
        logic offset_hi;
        logic scp;
        logic cur_hi;
    } flt_in_s;

    typedef struct packed {
        logic perm;
        logic open_tw;
        logic offset;
        logic open_ld;
        logic across;
        logic vs_short;
        logic gnd;
        logic done;
    } result_s;

    typedef enum logic [2:0] {
        TS_STBY = 3'h1,
        TS_PULSE = 3'h2,
        TS_BIAS = 3'h4
    } ton_state_e;

    typedef enum logic [3:0] {
        CS_ACTIVE = 4'h1,
        CS_RECHECK = 4'h2,
        CS_DIAG = 4'h4,
        CS_RESTART = 4'h8
    } chan_state_e;

endpackage

// File: tb/load_model.sv
// Speaker and output-stage model that drives the fault comparator levels
`timescale 1ns/100ps
`default_nettype none

module load_model (
    // Stage state and injected faults
    input wire logic stage_standby,
    input wire diag_pkg::flt_in_s [3:0] fault,
    input wire logic [3:0] tone,
    // Comparator levels
    output var diag_pkg::flt_in_s [3:0] flt_in
);
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            flt_in[i] = fault[i];
            // Overload only trips while the stage drives the load
            flt_in[i].scp = !stage_standby && (fault[i].gnd_pos || fault[i].gnd_neg ||
                fault[i].vs_short || fault[i].across);
            // No current pulses while the stage is parked
            flt_in[i].cur_hi = tone[i] && !stage_standby;
        end
    end
endmodule

`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the output-fault diagnostics sequencer
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic stage_standby;
    logic outputs_hiz;
    logic test_pulse;
    logic [3:0] chan_en;
    logic [3:0] line_thr_sel;
    logic [3:0] tone = 4'h0;
    diag_pkg::flt_in_s [3:0] fault = '0;
    diag_pkg::flt_in_s [3:0] flt_in;
    logic [6:0] mon;
    logic [31:0] rd;
    logic [31:0] lt_ctrl [5] = '{32'h64, 32'h68, 32'h6c, 32'h4c, 32'h60};
    logic [3:0] lt_exp [5] = '{4'h5, 4'ha, 4'hf, 4'h0, 4'h0};
    int waited;
    int n_fail = 0;
    int cmp_count = 0;

    assign mon = {outputs_hiz, stage_standby, test_pulse, chan_en};

    always #2 clk = ~clk;

    // Short counts keep the run brief
    amp_output_fault_diagnostics #(.RECHECK_CYCLES(20), .DIAG_CYCLES(40)) uut (
        .clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .flt_in(flt_in), .stage_standby(stage_standby), .outputs_hiz(outputs_hiz),
        .test_pulse(test_pulse), .chan_en(chan_en), .line_thr_sel(line_thr_sel)
    );

    load_model far_end (
        .stage_standby(stage_standby), .fault(fault), .tone(tone), .flt_in(flt_in)
    );

    task automatic test_done();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        n_fail++;
        $display("ERROR at %0t: %s", $time, msg);
    endtask

    task automatic chk32(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] mask);
        cmp_count++;
        if ((got & mask) !== exp) begin
            fail($sformatf("word %h, expected %h", got & mask, exp));
        end
    endtask

    task automatic chk1(input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            fail("flag mismatch");
        end
    endtask

    // One Avalon access; read data land in rd
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k == 50) begin
            fail("bus answer missing");
            test_done();
        end
    endtask

    task automatic wait_mon(input int idx, input logic val, input int lim);
        for (waited = 0; waited < lim; waited++) begin
            @(posedge clk);
            if (mon[idx] === val) break;
        end
        if (waited == lim) begin
            fail("wait ran out");
            test_done();
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Two reads: the second returns what the first captured
    task automatic read_twice();
        bus(1'b0, diag_pkg::STATUS_ADDR, 32'h0);
        bus(1'b0, diag_pkg::STATUS_ADDR, 32'h0);
    endtask

    initial begin
        idle(6);
        rstn <= 1'b1;
        idle(3);
        bus(1'b0, diag_pkg::CTRL_ADDR, 32'h0);
        chk32(32'h0, rd, '1);
        chk1(1'b1, stage_standby);
        $display("reset test finished");

        // Turn-on pulse with double faults on channels 0 to 2, open load alone on channel 3
        fault <= 32'h08886090;
        idle(5);
        bus(1'b1, diag_pkg::CTRL_ADDR, 32'h41);
        wait_mon(4, 1'b1, 20);
        chk1(1'b1, stage_standby);
        chk1(1'b1, outputs_hiz);
        wait_mon(4, 1'b0, 60);
        chk1(1'b1, waited >= 38 && waited <= 41);
        fault <= '0;
        wait_mon(5, 1'b0, 10);
        idle(40);
        bus(1'b0, diag_pkg::STATUS_ADDR, 32'h0);
        chk32(32'h0, rd, '1);
        bus(1'b0, diag_pkg::STATUS_ADDR, 32'h0);
        chk32(32'h11110703, rd, '1);
        $display("turn-on test finished");

        // Permanent diagnostic: glitch, then a lasting short with open load
        fault <= 32'h10000000;
        idle(3);
        fault <= '0;
        idle(30);
        chk1(1'b1, chan_en[3]);
        fault <= 32'h00002800;
        idle(75);
        chk32(32'hd, {28'h0, chan_en}, '1);
        fault <= '0;
        wait_mon(1, 1'b1, 60);
        read_twice();
        chk32(32'h00008400, rd, 32'h00008400);
        chk32(32'h0, rd, 32'h00001000);
        $display("permanent test finished");

        // Restart mode with diagnostics defeated
        bus(1'b1, diag_pkg::CTRL_ADDR, 32'h40);
        fault <= 32'h00800000;
        idle(10);
        chk32(32'hb, {28'h0, chan_en}, '1);
        bus(1'b0, diag_pkg::STATE_ADDR, 32'h0);
        chk32(32'h4181100b, rd, '1);
        fault <= '0;
        wait_mon(2, 1'b1, 60);
        $display("restart test finished");

        // Offset and tweeter detection, then suppression by overload
        fault <= 32'h00000404;
        idle(5);
        bus(1'b1, diag_pkg::CTRL_ADDR, 32'h53);
        for (int i = 0; i < 3; i++) begin
            tone <= (i < 2) ? 4'h3 : 4'h1;
            idle(4);
            tone <= 4'h0;
            idle(4);
        end
        fault <= 32'h04000004;
        idle(10);
        read_twice();
        chk32(32'h00000020, rd, 32'h20002020);
        chk32(32'h00404000, rd, 32'h00404040);
        fault <= 32'h04000014;
        idle(3);
        fault <= 32'h04000004;
        idle(30);
        read_twice();
        chk32(32'h20000000, rd, 32'h20000060);
        $display("offset test finished");

        // Threshold select over gain and line-driver settings
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, diag_pkg::CTRL_ADDR, lt_ctrl[i]);
            idle(2);
            chk32({28'h0, lt_exp[i]}, {28'h0, line_thr_sel}, '1);
        end
        bus(1'b1, 4'hc, 32'h7f);
        bus(1'b0, diag_pkg::CTRL_ADDR, 32'h0);
        chk32(32'h60, rd, 32'h7f);
        bus(1'b0, 4'hc, 32'h0);
        chk32(32'h0, rd, '1);
        $display("threshold test finished");
        test_done();
    end
endmodule

`default_nettype wire
